// File: design/sfb_bank_one.sv
// sfb_bank_one: bank-one special-function registers and their bank-zero mirrors
// assumes: core drives addr/wdata/strobes on clock; rstn is the power-up/brown-out reset
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
module sfb_bank_one import sfb_pkg::*; (
	input wire logic clock,
	input wire logic rstn,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	output logic [7:0] rdata,
	input wire logic external_reset_pin_n,
	input wire logic watchdog_timeout,
	input wire logic brownout_reset_flag,
	input wire logic time_out_n,
	input wire logic power_down_n,
	input wire logic alu_flags_we,
	input wire logic [2:0] alu_flags,
	input wire logic [2:0] irq_flag_set,
	input wire logic pc_step,
	input wire logic [5:0] serial_state,
	input wire logic uart_shift_empty,
	output logic [12:0] program_counter,
	output logic direct_bank_select,
	output logic [7:0] prescaler_option_config,
	output logic [7:0] port_a_direction,
	output logic [7:0] port_b_direction,
	output logic [7:0] port_c_direction,
	output logic [7:0] interrupt_control,
	output logic [7:0] peripheral_irq_enable_one,
	output logic [7:0] peripheral_irq_enable_two,
	output logic [7:0] power_control,
	output logic [7:0] timer_two_period,
	output logic [7:0] serial_port_slave_address,
	output logic [7:0] uart_transmit_control,
	output logic [7:0] baud_divisor
);
	// ----------------------------------------
	// address helpers
	// ----------------------------------------
	function automatic logic is_mirror(input logic [7:0] a);
		logic [7:0] n;
		n = {1'b1, a[6:0]};
		is_mirror = (n == SFB_OFS_INDIRECT_ACCESS_PORT) || (n == SFB_OFS_PROGRAM_COUNTER_LOW) ||
			(n == SFB_OFS_CORE_STATUS) || (n == SFB_OFS_INDIRECT_POINTER) ||
			(n == SFB_OFS_COUNTER_HIGH_WRITE_BUFFER) || (n == SFB_OFS_INTERRUPT_CONTROL);
	endfunction

	function automatic logic bank_hit(input logic [7:0] a);
		bank_hit = a[7] | is_mirror(a);
	endfunction

	function automatic logic [7:0] bank_norm(input logic [7:0] a);
		bank_norm = {1'b1, a[6:0]};
	endfunction

	// ----------------------------------------
	// reset pin synchroniser and reset kinds
	// ----------------------------------------
	logic pin_s1_reg;
	logic pin_s2_reg;
	logic brown_s1_reg;
	logic brown_s2_reg;
	logic soft_reset;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pin_s1_reg <= 1'b1;
			pin_s2_reg <= 1'b1;
			brown_s1_reg <= 1'b0;
			brown_s2_reg <= 1'b0;
		end else begin
			pin_s1_reg <= external_reset_pin_n;
			pin_s2_reg <= pin_s1_reg;
			brown_s1_reg <= brownout_reset_flag;
			brown_s2_reg <= brown_s1_reg;
		end
	end

	assign soft_reset = !pin_s2_reg || watchdog_timeout;

	// ----------------------------------------
	// register state
	// ----------------------------------------
	logic [7:0] option_reg, option_next;
	logic [7:0] status_reg, status_next;
	logic [7:0] pointer_reg, pointer_next;
	logic [7:0] tris_a_reg, tris_a_next;
	logic [7:0] tris_b_reg, tris_b_next;
	logic [7:0] tris_c_reg, tris_c_next;
	logic [7:0] buffer_reg, buffer_next;
	logic [7:0] irq_ctl_reg, irq_ctl_next;
	logic [7:0] pie_one_reg, pie_one_next;
	logic [7:0] pie_two_reg, pie_two_next;
	logic [7:0] pwr_ctl_reg, pwr_ctl_next;
	logic [7:0] period_reg, period_next;
	logic [7:0] slave_reg, slave_next;
	logic [7:0] tx_reg, tx_next;
	logic [7:0] baud_reg, baud_next;
	logic [1:0] cause_wait_reg, cause_wait_next;
	logic [7:0] rdata_reg, rdata_next;

	// ----------------------------------------
	// access decode
	// ----------------------------------------
	logic dir_hit;
	logic [7:0] dir_addr;
	logic indirect;
	logic tgt_hit;
	logic [7:0] tgt;
	logic pc_low_write;
	logic [7:0] read_value;

	always_comb begin
		dir_hit = bank_hit(addr);
		dir_addr = bank_norm(addr);
		indirect = dir_hit && (dir_addr == SFB_OFS_INDIRECT_ACCESS_PORT);
		// pointer is used as a plain 8-bit address; bank-select bits kept zero
		tgt_hit = indirect ? bank_hit(pointer_reg) : dir_hit;
		tgt = indirect ? bank_norm(pointer_reg) : dir_addr;
		pc_low_write = wr_stb && !soft_reset && tgt_hit && (tgt == SFB_OFS_PROGRAM_COUNTER_LOW);
	end

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	always_comb begin
		read_value = 8'h00;
		if (tgt_hit) begin
			case (tgt)
				SFB_OFS_PRESCALER_OPTION_CONFIG: read_value = option_reg;
				SFB_OFS_PROGRAM_COUNTER_LOW: read_value = program_counter[7:0];
				SFB_OFS_CORE_STATUS: read_value = status_reg;
				SFB_OFS_INDIRECT_POINTER: read_value = pointer_reg;
				SFB_OFS_PORT_A_DIRECTION: read_value = tris_a_reg;
				SFB_OFS_PORT_B_DIRECTION: read_value = tris_b_reg;
				SFB_OFS_PORT_C_DIRECTION: read_value = tris_c_reg;
				SFB_OFS_COUNTER_HIGH_WRITE_BUFFER: read_value = buffer_reg;
				SFB_OFS_INTERRUPT_CONTROL: read_value = irq_ctl_reg;
				SFB_OFS_PERIPHERAL_IRQ_ENABLE_ONE: read_value = pie_one_reg;
				SFB_OFS_PERIPHERAL_IRQ_ENABLE_TWO: read_value = pie_two_reg;
				SFB_OFS_POWER_CONTROL: read_value = pwr_ctl_reg;
				SFB_OFS_TIMER_TWO_PERIOD: read_value = period_reg;
				SFB_OFS_SERIAL_PORT_SLAVE_ADDRESS: read_value = slave_reg;
				SFB_OFS_SERIAL_PORT_STATE: read_value = {2'h0, serial_state} & SFB_MASK_SERIAL_PORT_STATE;
				SFB_OFS_UART_TRANSMIT_CONTROL: begin
					read_value = tx_reg;
					read_value[SFB_BIT_SHIFT_EMPTY] = uart_shift_empty;
				end
				SFB_OFS_BAUD_DIVISOR: read_value = baud_reg;
				default: read_value = 8'h00;
			endcase
		end
		rdata_next = rd_stb ? read_value : 8'h00;
	end

	// ----------------------------------------
	// register next values
	// ----------------------------------------
	always_comb begin
		option_next = option_reg;
		status_next = status_reg;
		pointer_next = pointer_reg;
		tris_a_next = tris_a_reg;
		tris_b_next = tris_b_reg;
		tris_c_next = tris_c_reg;
		buffer_next = buffer_reg;
		irq_ctl_next = irq_ctl_reg;
		pie_one_next = pie_one_reg;
		pie_two_next = pie_two_reg;
		pwr_ctl_next = pwr_ctl_reg;
		period_next = period_reg;
		slave_next = slave_reg;
		tx_next = tx_reg;
		baud_next = baud_reg;
		cause_wait_next = (cause_wait_reg != 2'h0) ? cause_wait_reg - 2'h1 : 2'h0;
		if (soft_reset) begin
			// other-reset values; pointer and cause flags unchanged
			option_next = SFB_RST_OPTION;
			status_next = status_reg & SFB_MASK_STATUS_KEEP;
			status_next[SFB_BIT_TIME_OUT] = time_out_n;
			status_next[SFB_BIT_POWER_DOWN] = power_down_n;
			tris_a_next = SFB_RST_PORT_A_DIRECTION;
			tris_b_next = SFB_RST_PORT_B_DIRECTION;
			tris_c_next = SFB_RST_PORT_C_DIRECTION;
			buffer_next = SFB_RST_WRITE_BUFFER;
			irq_ctl_next = irq_ctl_reg & SFB_MASK_INTERRUPT_KEEP;
			pie_one_next = SFB_RST_IRQ_ENABLE;
			pie_two_next = SFB_RST_IRQ_ENABLE;
			period_next = SFB_RST_TIMER_TWO_PERIOD;
			slave_next = SFB_RST_SLAVE_ADDRESS;
			tx_next = SFB_RST_TX_CONTROL;
			baud_next = SFB_RST_BAUD_DIVISOR;
		end else begin
			if (alu_flags_we) begin
				status_next[2:0] = alu_flags;
			end
			if (wr_stb && tgt_hit) begin
				case (tgt)
					SFB_OFS_PRESCALER_OPTION_CONFIG: option_next = wdata;
					SFB_OFS_CORE_STATUS: begin
						status_next = (wdata & SFB_MASK_STATUS_SW) | (status_reg & ~SFB_MASK_STATUS_SW);
					end
					SFB_OFS_INDIRECT_POINTER: pointer_next = wdata;
					SFB_OFS_PORT_A_DIRECTION: tris_a_next = wdata & SFB_MASK_PORT_A_DIRECTION;
					SFB_OFS_PORT_B_DIRECTION: tris_b_next = wdata;
					SFB_OFS_PORT_C_DIRECTION: tris_c_next = wdata;
					SFB_OFS_COUNTER_HIGH_WRITE_BUFFER: buffer_next = wdata & SFB_MASK_WRITE_BUFFER;
					SFB_OFS_INTERRUPT_CONTROL: irq_ctl_next = wdata;
					SFB_OFS_PERIPHERAL_IRQ_ENABLE_ONE: pie_one_next = wdata;
					SFB_OFS_PERIPHERAL_IRQ_ENABLE_TWO: pie_two_next = wdata & SFB_MASK_IRQ_ENABLE_TWO;
					SFB_OFS_POWER_CONTROL: pwr_ctl_next = wdata & SFB_MASK_POWER_CONTROL;
					SFB_OFS_TIMER_TWO_PERIOD: period_next = wdata;
					SFB_OFS_SERIAL_PORT_SLAVE_ADDRESS: slave_next = wdata;
					SFB_OFS_UART_TRANSMIT_CONTROL: tx_next = wdata & SFB_MASK_TX_CONTROL_SW;
					SFB_OFS_BAUD_DIVISOR: baud_next = wdata;
					default: begin
					end
				endcase
			end
		end
		// hardware flag set wins over a same-cycle clear
		irq_ctl_next[2:0] = irq_ctl_next[2:0] | irq_flag_set;
		// power-up cause captured once the synchronised level is valid
		if (cause_wait_reg == 2'h1) begin
			pwr_ctl_next[SFB_BIT_POWER_ON_FLAG] = brown_s2_reg;
			pwr_ctl_next[SFB_BIT_BROWNOUT_FLAG] = !brown_s2_reg;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			option_reg <= SFB_RST_OPTION;
			status_reg <= SFB_RST_STATUS;
			pointer_reg <= SFB_RST_POINTER;
			tris_a_reg <= SFB_RST_PORT_A_DIRECTION;
			tris_b_reg <= SFB_RST_PORT_B_DIRECTION;
			tris_c_reg <= SFB_RST_PORT_C_DIRECTION;
			buffer_reg <= SFB_RST_WRITE_BUFFER;
			irq_ctl_reg <= SFB_RST_INTERRUPT_CONTROL;
			pie_one_reg <= SFB_RST_IRQ_ENABLE;
			pie_two_reg <= SFB_RST_IRQ_ENABLE;
			pwr_ctl_reg <= SFB_RST_POWER_CONTROL;
			period_reg <= SFB_RST_TIMER_TWO_PERIOD;
			slave_reg <= SFB_RST_SLAVE_ADDRESS;
			tx_reg <= SFB_RST_TX_CONTROL;
			baud_reg <= SFB_RST_BAUD_DIVISOR;
			cause_wait_reg <= SFB_CAUSE_WAIT;
			rdata_reg <= 8'h00;
		end else begin
			option_reg <= option_next;
			status_reg <= status_next;
			pointer_reg <= pointer_next;
			tris_a_reg <= tris_a_next;
			tris_b_reg <= tris_b_next;
			tris_c_reg <= tris_c_next;
			buffer_reg <= buffer_next;
			irq_ctl_reg <= irq_ctl_next;
			pie_one_reg <= pie_one_next;
			pie_two_reg <= pie_two_next;
			pwr_ctl_reg <= pwr_ctl_next;
			period_reg <= period_next;
			slave_reg <= slave_next;
			tx_reg <= tx_next;
			baud_reg <= baud_next;
			cause_wait_reg <= cause_wait_next;
			rdata_reg <= rdata_next;
		end
	end

	// ----------------------------------------
	// program counter
	// ----------------------------------------
	sfb_pc_unit u_pc (
		.clock(clock),
		.rstn(rstn),
		.soft_reset(soft_reset),
		.step(pc_step),
		.low_write(pc_low_write),
		.low_wdata(wdata),
		.write_buffer(buffer_reg[4:0]),
		.program_counter(program_counter)
	);

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign rdata = rdata_reg;
	assign direct_bank_select = status_reg[SFB_BIT_DIRECT_BANK];
	assign prescaler_option_config = option_reg;
	assign port_a_direction = tris_a_reg;
	assign port_b_direction = tris_b_reg;
	assign port_c_direction = tris_c_reg;
	assign interrupt_control = irq_ctl_reg;
	assign peripheral_irq_enable_one = pie_one_reg;
	assign peripheral_irq_enable_two = pie_two_reg;
	assign power_control = pwr_ctl_reg;
	assign timer_two_period = period_reg;
	assign serial_port_slave_address = slave_reg;
	assign uart_transmit_control = tx_reg;
	assign baud_divisor = baud_reg;
endmodule // sfb_bank_one

// File: design/sfb_pc_unit.sv
// sfb_pc_unit: 13-bit program counter with low byte written by software
// assumes: core pulses step once per fetched word, same clock
`timescale 1ns/1ps
module sfb_pc_unit import sfb_pkg::*; (
	input wire logic clock,
	input wire logic rstn,
	input wire logic soft_reset,
	input wire logic step,
	input wire logic low_write,
	input wire logic [7:0] low_wdata,
	input wire logic [4:0] write_buffer,
	output logic [12:0] program_counter
);
	logic [12:0] pc_reg;
	logic [12:0] pc_next;

	// ----------------------------------------
	// next counter value
	// ----------------------------------------
	always_comb begin
		pc_next = pc_reg;
		if (soft_reset) begin
			pc_next = SFB_RST_PROGRAM_COUNTER;
		end else if (low_write) begin
			pc_next = {write_buffer, low_wdata};
		end else if (step) begin
			pc_next = pc_reg + 13'h0001;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pc_reg <= SFB_RST_PROGRAM_COUNTER;
		end else begin
			pc_reg <= pc_next;
		end
	end

	assign program_counter = pc_reg;
endmodule // sfb_pc_unit

// File: design/sfb_pkg.sv
// sfb_pkg: offsets, masks, reset values and timing counts of the bank-one register block
// assumes: one 8-bit core data bus, bank one at 0x80..0xff
package sfb_pkg;

	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] SFB_OFS_INDIRECT_ACCESS_PORT = 8'h80;
	localparam logic [7:0] SFB_OFS_PRESCALER_OPTION_CONFIG = 8'h81;
	localparam logic [7:0] SFB_OFS_PROGRAM_COUNTER_LOW = 8'h82;
	localparam logic [7:0] SFB_OFS_CORE_STATUS = 8'h83;
	localparam logic [7:0] SFB_OFS_INDIRECT_POINTER = 8'h84;
	localparam logic [7:0] SFB_OFS_PORT_A_DIRECTION = 8'h85;
	localparam logic [7:0] SFB_OFS_PORT_B_DIRECTION = 8'h86;
	localparam logic [7:0] SFB_OFS_PORT_C_DIRECTION = 8'h87;
	localparam logic [7:0] SFB_OFS_COUNTER_HIGH_WRITE_BUFFER = 8'h8a;
	localparam logic [7:0] SFB_OFS_INTERRUPT_CONTROL = 8'h8b;
	localparam logic [7:0] SFB_OFS_PERIPHERAL_IRQ_ENABLE_ONE = 8'h8c;
	localparam logic [7:0] SFB_OFS_PERIPHERAL_IRQ_ENABLE_TWO = 8'h8d;
	localparam logic [7:0] SFB_OFS_POWER_CONTROL = 8'h8e;
	localparam logic [7:0] SFB_OFS_TIMER_TWO_PERIOD = 8'h92;
	localparam logic [7:0] SFB_OFS_SERIAL_PORT_SLAVE_ADDRESS = 8'h93;
	localparam logic [7:0] SFB_OFS_SERIAL_PORT_STATE = 8'h94;
	localparam logic [7:0] SFB_OFS_UART_TRANSMIT_CONTROL = 8'h98;
	localparam logic [7:0] SFB_OFS_BAUD_DIVISOR = 8'h99;

	// ----------------------------------------
	// implemented bits
	// ----------------------------------------
	localparam logic [7:0] SFB_MASK_PORT_A_DIRECTION = 8'h3f;
	localparam logic [7:0] SFB_MASK_WRITE_BUFFER = 8'h1f;
	localparam logic [7:0] SFB_MASK_IRQ_ENABLE_TWO = 8'h01;
	localparam logic [7:0] SFB_MASK_POWER_CONTROL = 8'h03;
	localparam logic [7:0] SFB_MASK_SERIAL_PORT_STATE = 8'h3f;
	localparam logic [7:0] SFB_MASK_TX_CONTROL_SW = 8'hf5;
	localparam logic [7:0] SFB_MASK_STATUS_SW = 8'he7;
	localparam logic [7:0] SFB_MASK_STATUS_KEEP = 8'h07;
	localparam logic [7:0] SFB_MASK_INTERRUPT_KEEP = 8'h01;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int SFB_BIT_DIRECT_BANK = 5;
	localparam int SFB_BIT_TIME_OUT = 4;
	localparam int SFB_BIT_POWER_DOWN = 3;
	localparam int SFB_BIT_POWER_ON_FLAG = 1;
	localparam int SFB_BIT_BROWNOUT_FLAG = 0;
	localparam int SFB_BIT_SHIFT_EMPTY = 1;

	// ----------------------------------------
	// reset values (power-up / brown-out)
	// ----------------------------------------
	localparam logic [7:0] SFB_RST_OPTION = 8'hff;
	localparam logic [7:0] SFB_RST_STATUS = 8'h18;
	localparam logic [7:0] SFB_RST_POINTER = 8'h00;
	localparam logic [7:0] SFB_RST_PORT_A_DIRECTION = 8'h3f;
	localparam logic [7:0] SFB_RST_PORT_B_DIRECTION = 8'hff;
	localparam logic [7:0] SFB_RST_PORT_C_DIRECTION = 8'hff;
	localparam logic [7:0] SFB_RST_WRITE_BUFFER = 8'h00;
	localparam logic [7:0] SFB_RST_INTERRUPT_CONTROL = 8'h00;
	localparam logic [7:0] SFB_RST_IRQ_ENABLE = 8'h00;
	localparam logic [7:0] SFB_RST_POWER_CONTROL = 8'h00;
	localparam logic [7:0] SFB_RST_TIMER_TWO_PERIOD = 8'hff;
	localparam logic [7:0] SFB_RST_SLAVE_ADDRESS = 8'h00;
	localparam logic [7:0] SFB_RST_TX_CONTROL = 8'h00;
	localparam logic [7:0] SFB_RST_BAUD_DIVISOR = 8'h00;
	localparam logic [12:0] SFB_RST_PROGRAM_COUNTER = 13'h0000;

	// ----------------------------------------
	// timing counts
	// ----------------------------------------
	localparam logic [1:0] SFB_CAUSE_WAIT = 2'h3;

endpackage

// File: tb/sfb_bank_one_bench.sv
// sfb_bank_one_bench: self-checking bench for the bank-one register block
// assumes: 20 MHz clock, core model drives the register port
`timescale 1ns/1ps
module sfb_bank_one_bench import sfb_pkg::*; ;
	logic clock, rstn, wr_stb, rd_stb, external_reset_pin_n, watchdog_timeout;
	logic brownout_reset_flag, time_out_n, power_down_n, pc_step, uart_shift_empty;
	logic [7:0] addr, wdata, rdata, interrupt_control, power_control, baud_divisor;
	logic [7:0] prescaler_option_config, port_a_direction, port_b_direction, port_c_direction;
	logic [7:0] peripheral_irq_enable_one, peripheral_irq_enable_two, timer_two_period;
	logic [7:0] serial_port_slave_address, uart_transmit_control;
	logic [5:0] serial_state;
	logic [12:0] program_counter;
	logic direct_bank_select;
	logic alu_flags_we = 1'b0;
	logic [2:0] alu_flags = 3'h0;
	logic [2:0] irq_flag_set = 3'h0;
	int mismatches = 0;
	int samples_checked = 0;
	// rows: address, readback before write, write value, readback after write
	logic [31:0] rows [20] = '{32'h81ffa5a5, 32'h84008c8c, 32'h853fff3f, 32'h86ff5a5a,
		32'h87ff0f0f, 32'h8a00ff1f, 32'h8c003c3c, 32'h8d00ff01, 32'h803c0c0c, 32'h8e010000,
		32'h92ff1212, 32'h93007777, 32'h942aff2a, 32'h9802fff7, 32'h9900c3c3, 32'h03182038,
		32'h0b00f8f8, 32'h8800ff00, 32'h9f00ff00, 32'h0d00ff00};
	sfb_bank_one dut (.clock, .rstn, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .external_reset_pin_n,
		.watchdog_timeout, .brownout_reset_flag, .time_out_n, .power_down_n, .alu_flags_we,
		.alu_flags, .irq_flag_set, .pc_step, .serial_state, .uart_shift_empty, .program_counter,
		.direct_bank_select, .prescaler_option_config, .port_a_direction, .port_b_direction,
		.port_c_direction, .interrupt_control, .peripheral_irq_enable_one,
		.peripheral_irq_enable_two, .power_control, .timer_two_period, .serial_port_slave_address,
		.uart_transmit_control, .baud_divisor);
	sfb_core_model core (.clock, .rdata, .addr, .wdata, .wr_stb, .rd_stb);
	// ----------------------------------------
	// checking and verdict
	// ----------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		$display("checked %0d values, %0d mismatches", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// ----------------------------------------
	// stimulus
	// ----------------------------------------
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	initial begin
		repeat (20000) @(posedge clock);
		mismatches++;
		$display("MISMATCH at %0t: run did not finish", $time);
		summarize();
	end
	initial begin
		logic [7:0] seen;
		rstn = 1'b0;
		external_reset_pin_n = 1'b1;
		watchdog_timeout = 1'b0;
		brownout_reset_flag = 1'b0;
		time_out_n = 1'b1;
		power_down_n = 1'b1;
		pc_step = 1'b0;
		serial_state = 6'h2a;
		uart_shift_empty = 1'b1;
		repeat (16) @(posedge clock);
		rstn <= 1'b1;
		@(posedge clock);
		foreach (rows[i]) begin
			core.read(rows[i][31:24], seen);
			check(seen, rows[i][23:16]);
			core.write(rows[i][31:24], rows[i][15:8]);
			core.read(rows[i][31:24], seen);
			check(seen, rows[i][7:0]);
		end
		check(prescaler_option_config, 8'ha5);
		check(port_b_direction, 8'h5a);
		check(port_c_direction, 8'h0f);
		check(peripheral_irq_enable_one, 8'h0c);
		check(peripheral_irq_enable_two, 8'h01);
		check(serial_port_slave_address, 8'h77);
		check(uart_transmit_control, 8'hf5);
		check(timer_two_period, 8'h12);
		check(interrupt_control, 8'hf8);
		check({7'h00, direct_bank_select}, 8'h01);
		$display("test register table done");
		core.read(8'h8b, seen);
		check(seen, 8'hf8);
		core.read(8'h83, seen);
		check(seen, 8'h38);
		core.write(8'h0a, 8'h15);
		core.read(8'h8a, seen);
		check(seen, 8'h15);
		core.write(8'h82, 8'h34);
		pc_step <= 1'b1;
		core.idle();
		pc_step <= 1'b0;
		core.idle();
		check(program_counter[7:0], 8'h35);
		check({3'h0, program_counter[12:8]}, 8'h15);
		$display("test counter load done");
		core.write(8'h8e, 8'h03);
		core.write(8'h99, 8'h5a);
		time_out_n <= 1'b0;
		watchdog_timeout <= 1'b1;
		core.idle();
		watchdog_timeout <= 1'b0;
		time_out_n <= 1'b1;
		core.idle();
		check(baud_divisor, 8'h00);
		check(prescaler_option_config, 8'hff);
		check(power_control, 8'h03);
		core.read(8'h83, seen);
		check(seen, 8'h08);
		core.read(8'h84, seen);
		check(seen, 8'h8c);
		$display("test watchdog reset done");
		core.write(8'h99, 8'hc3);
		core.write(8'h85, 8'h00);
		external_reset_pin_n <= 1'b0;
		power_down_n <= 1'b0;
		repeat (4) core.idle();
		external_reset_pin_n <= 1'b1;
		repeat (4) core.idle();
		power_down_n <= 1'b1;
		check(baud_divisor, 8'h00);
		check(port_a_direction, 8'h3f);
		check(power_control, 8'h03);
		core.read(8'h83, seen);
		check(seen, 8'h10);
		$display("test pin reset done");
		irq_flag_set <= 3'h5;
		alu_flags_we <= 1'b1;
		alu_flags <= 3'h6;
		core.write(8'h8b, 8'h00);
		irq_flag_set <= 3'h0;
		alu_flags_we <= 1'b0;
		uart_shift_empty <= 1'b0;
		core.read(8'h8b, seen);
		check(seen, 8'h05);
		core.read(8'h83, seen);
		check(seen, 8'h16);
		core.read(8'h98, seen);
		check(seen, 8'h00);
		$display("test flag inputs done");
		core.write(8'h99, 8'h66);
		core.idle();
		rstn <= 1'b0;
		brownout_reset_flag <= 1'b1;
		repeat (16) @(posedge clock);
		rstn <= 1'b1;
		repeat (6) @(posedge clock);
		check(power_control, 8'h02);
		check(baud_divisor, 8'h00);
		$display("test brown-out reset done");
		summarize();
	end
endmodule // sfb_bank_one_bench
bind sfb_bank_one sfb_bank_one_checker chk (.clock, .rstn, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
	.external_reset_pin_n, .watchdog_timeout, .brownout_reset_flag, .pc_step, .program_counter,
	.direct_bank_select, .prescaler_option_config, .port_b_direction, .interrupt_control,
	.power_control, .timer_two_period, .baud_divisor);

// File: tb/sfb_bank_one_properties.sv
// sfb_bank_one_properties: concurrent checks on the bank-one register port
// assumes: bound to sfb_bank_one, one clock, rstn is the active-low power-up reset
`timescale 1ns/1ps
module sfb_bank_one_checker import sfb_pkg::*; (
	input wire logic clock,
	input wire logic rstn,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	input wire logic [7:0] rdata,
	input wire logic external_reset_pin_n,
	input wire logic watchdog_timeout,
	input wire logic brownout_reset_flag,
	input wire logic pc_step,
	input wire logic [12:0] program_counter,
	input wire logic direct_bank_select,
	input wire logic [7:0] prescaler_option_config,
	input wire logic [7:0] port_b_direction,
	input wire logic [7:0] interrupt_control,
	input wire logic [7:0] power_control,
	input wire logic [7:0] timer_two_period,
	input wire logic [7:0] baud_divisor
);
	// ----------------------------------------
	// helper state
	// ----------------------------------------
	logic [1:0] rel_cnt_reg, rel_cnt_next;
	logic [2:0] pin_hist_reg, pin_hist_next;
	logic quiet;
	always_comb begin
		rel_cnt_next = (rel_cnt_reg == 2'd3) ? rel_cnt_reg : rel_cnt_reg + 2'd1;
		pin_hist_next = {pin_hist_reg[1:0], external_reset_pin_n};
		quiet = !watchdog_timeout && external_reset_pin_n && (&pin_hist_reg);
	end
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rel_cnt_reg <= 2'd0;
			pin_hist_reg <= 3'b111;
		end else begin
			rel_cnt_reg <= rel_cnt_next;
			pin_hist_reg <= pin_hist_next;
		end
	end
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking @(posedge clock);
	endclocking
	default disable iff (!rstn);
	chk_unmapped_reads_zero: assert property (
		rd_stb && addr inside {8'h88, 8'h89, [8'h8f:8'h91], [8'h95:8'h97], [8'h9a:8'h9f]}
		|=> rdata == 8'h00) else $error("unmapped read not zero");
	chk_read_data_idle: assert property (!rd_stb |=> rdata == 8'h00)
		else $error("stray read data");
	chk_mirror_buffer_read: assert property (
		wr_stb && addr == 8'h0a && quiet ##1 rd_stb && addr == 8'h8a
		|=> rdata == ($past(wdata, 2) & SFB_MASK_WRITE_BUFFER)) else $error("buffer mirror wrong");
	chk_status_bank_bit: assert property (wr_stb && addr[6:0] == 7'h03 && quiet
		|=> direct_bank_select == $past(wdata[5])) else $error("status write lost");
	chk_pc_upper_hold: assert property (!(wr_stb && addr[6:0] == 7'h02) && !pc_step && quiet
		|=> $stable(program_counter[12:8])) else $error("counter upper bits moved");
	chk_pc_low_load: assert property (wr_stb && addr[6:0] == 7'h02 && quiet
		|=> program_counter[7:0] == $past(wdata)) else $error("counter low byte not loaded");
	chk_other_reset_values: assert property (watchdog_timeout
		|=> prescaler_option_config == 8'hff
		&& port_b_direction == 8'hff && timer_two_period == 8'hff && interrupt_control[7:3] == 5'h00)
		else $error("other reset values wrong");
	chk_cause_flags_keep: assert property (watchdog_timeout && rel_cnt_reg == 2'd3
		|=> $stable(power_control)) else $error("cause flags changed on other reset");
	chk_cause_flags_capture: assert property (rel_cnt_reg == 2'd2 |=> ##1
		power_control[1:0] == {brownout_reset_flag, !brownout_reset_flag}) else $error("cause flags wrong");
	chk_baud_other_clear: assert property (watchdog_timeout |=> baud_divisor == 8'h00)
		else $error("baud divisor not cleared");
	chk_baud_write_lands: assert property (wr_stb && addr == SFB_OFS_BAUD_DIVISOR && quiet
		|=> baud_divisor == $past(wdata)) else $error("baud divisor write lost");
endmodule // sfb_bank_one_checker

// File: tb/sfb_core_model.sv
// sfb_core_model: core data-memory master on the bank-one register port
// assumes: tasks are entered right after a rising clock edge
`timescale 1ns/1ps
module sfb_core_model import sfb_pkg::*; (
	input wire logic clock,
	input wire logic [7:0] rdata,
	output logic [7:0] addr,
	output logic [7:0] wdata,
	output logic wr_stb,
	output logic rd_stb
);
	// ----------------------------------------
	// bus cycles
	// ----------------------------------------
	initial begin
		addr = 8'h00;
		wdata = 8'h00;
		wr_stb = 1'b0;
		rd_stb = 1'b0;
	end
	task automatic idle();
		wr_stb <= 1'b0;
		rd_stb <= 1'b0;
		@(posedge clock);
	endtask
	task automatic write(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] v;
		v = d;
		if (a[6:0] == 7'h03) v[7:6] = 2'b00;
		if (a == SFB_OFS_PERIPHERAL_IRQ_ENABLE_ONE) v[7:6] = 2'b00;
		addr <= a;
		wdata <= v;
		wr_stb <= 1'b1;
		rd_stb <= 1'b0;
		@(posedge clock);
	endtask
	task automatic read(input logic [7:0] a, output logic [7:0] seen);
		addr <= a;
		wdata <= ~wdata;
		wr_stb <= 1'b0;
		rd_stb <= 1'b1;
		@(posedge clock);
		rd_stb <= 1'b0;
		#1 seen = rdata;
		@(posedge clock);
	endtask
endmodule // sfb_core_model
